// [hw/sfcu_defs.svh]
// Register map, field positions and reset values of the fault-clear and unlock block
`ifndef SFCU_DEFS_SVH
`define SFCU_DEFS_SVH

// Bus geometry: byte address, one 32-bit word per register
`define SFCU_ADDR_W 12
`define SFCU_IDX_W 10
`define SFCU_DATA_W 32
`define SFCU_BE_W 4
`define SFCU_REG_W 8

// Register indices; byte address is four times the index
`define SFCU_IDX_VCLR 10'h13e
`define SFCU_IDX_TCLR 10'h13f
`define SFCU_IDX_CONF_A 10'h150
`define SFCU_IDX_CONF_B 10'h151
`define SFCU_IDX_CONF_C 10'h152
`define SFCU_IDX_CONF_D 10'h153
`define SFCU_IDX_PROG_CTRL 10'h160
`define SFCU_IDX_IRQ_STAT 10'h170
`define SFCU_IDX_IRQ_MASK 10'h171
`define SFCU_IDX_UNLOCK_STAT 10'h172
`define SFCU_IDX_ERR_COUNT 10'h173

// Voltage self-test clear fields
`define SFCU_VCLR_UV_BIT 0
`define SFCU_VCLR_OV_BIT 1

// Temperature self-test clear fields
`define SFCU_TCLR_OT_BIT 0
`define SFCU_TCLR_UT_BIT 1
`define SFCU_TCLR_CH1_BIT 2
`define SFCU_TCLR_CH2_BIT 3
`define SFCU_TCLR_CH3_BIT 4
`define SFCU_TCLR_CH4_BIT 5
`define SFCU_TCLR_CH5_BIT 6
`define SFCU_TCLR_CH6_BIT 7

// Program control fields
`define SFCU_CTRL_LAUNCH_BIT 0

// Interrupt status and mask fields
`define SFCU_IRQ_W 5
`define SFCU_IRQ_OPEN_BIT 0
`define SFCU_IRQ_BREAK_BIT 1
`define SFCU_IRQ_WASTE_BIT 2
`define SFCU_IRQ_LAUNCH_BIT 3
`define SFCU_IRQ_REFUSE_BIT 4
`define SFCU_IRQ_STAT_RESET 5'h00
`define SFCU_IRQ_MASK_RESET 5'h00

// Unlock status fields
`define SFCU_UST_OPEN_BIT 0
`define SFCU_UST_STAGE_LSB 1
`define SFCU_UST_STAGE_MSB 3
`define SFCU_UST_STAGE1_BIT 4
`define SFCU_STAGE_W 3
`define SFCU_STAGE_NONE 3'h0
`define SFCU_STAGE_A 3'h1
`define SFCU_STAGE_B 3'h2
`define SFCU_STAGE_C 3'h3
`define SFCU_STAGE_OPEN 3'h4

// Error counter
`define SFCU_ERR_RESET 8'h00
`define SFCU_ERR_MAX 8'hff
`define SFCU_ERR_ONE 8'h01

// Bus answers
`define SFCU_RESP_OK 2'h0
`define SFCU_RESP_DECODE_ERR 2'h3
`define SFCU_RDATA_ZERO 32'h0000_0000
`define SFCU_CONF_READ 8'h00

`endif

// [hw/sfcu_pkg.sv]
// Types shared by the fault-clear and unlock block
package sfcu_pkg;

   typedef enum logic [2:0]
   {
      SEQ_IDLE,
      SEQ_GOT_A,
      SEQ_GOT_B,
      SEQ_GOT_C,
      SEQ_OPEN
   } sfcu_seq_t;

endpackage

// [hw/sfcu_unlock_seq.sv]
// Second-stage OTP unlock sequence tracker
`timescale 1ns/10ps
`include "sfcu_defs.svh"

module sfcu_unlock_seq
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic wr_any_in,
   input wire logic [3:0] step_in,
   input wire logic launch_in,
   input wire logic stage1_ok_in,
   output logic unlocked_out,
   output logic [`SFCU_STAGE_W-1:0] stage_out,
   output logic launch_out,
   output logic evt_open_out,
   output logic evt_break_out,
   output logic evt_waste_out,
   output logic evt_refuse_out
);

   sfcu_pkg::sfcu_seq_t state_q;

   // Sequence state
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         state_q <= sfcu_pkg::SEQ_IDLE;
      else if (wr_any_in)
      begin
         unique case (state_q)
            sfcu_pkg::SEQ_OPEN:
               state_q <= sfcu_pkg::SEQ_IDLE;
            sfcu_pkg::SEQ_IDLE:
               state_q <= step_in[0] ? sfcu_pkg::SEQ_GOT_A : sfcu_pkg::SEQ_IDLE;
            sfcu_pkg::SEQ_GOT_A:
               state_q <= step_in[1] ? sfcu_pkg::SEQ_GOT_B :
                  (step_in[0] ? sfcu_pkg::SEQ_GOT_A : sfcu_pkg::SEQ_IDLE);
            sfcu_pkg::SEQ_GOT_B:
               state_q <= step_in[2] ? sfcu_pkg::SEQ_GOT_C :
                  (step_in[0] ? sfcu_pkg::SEQ_GOT_A : sfcu_pkg::SEQ_IDLE);
            sfcu_pkg::SEQ_GOT_C:
               // Opening also needs the first stage to be in place
               state_q <= (step_in[3] && stage1_ok_in) ? sfcu_pkg::SEQ_OPEN :
                  (step_in[0] ? sfcu_pkg::SEQ_GOT_A : sfcu_pkg::SEQ_IDLE);
         endcase
      end
      else if (state_q == sfcu_pkg::SEQ_OPEN && !stage1_ok_in)
         state_q <= sfcu_pkg::SEQ_IDLE;
   end

   // Event pulses, one cycle each
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         launch_out <= 1'b0;
         evt_open_out <= 1'b0;
         evt_break_out <= 1'b0;
         evt_waste_out <= 1'b0;
         evt_refuse_out <= 1'b0;
      end
      else
      begin
         launch_out <= wr_any_in && launch_in && state_q == sfcu_pkg::SEQ_OPEN;
         evt_waste_out <= wr_any_in && !launch_in && state_q == sfcu_pkg::SEQ_OPEN;
         evt_refuse_out <= wr_any_in && launch_in && state_q != sfcu_pkg::SEQ_OPEN;
         evt_open_out <= wr_any_in && state_q == sfcu_pkg::SEQ_GOT_C && step_in[3] &&
            stage1_ok_in;
         evt_break_out <= wr_any_in && !step_in[0] &&
            ((state_q == sfcu_pkg::SEQ_GOT_A && !step_in[1]) ||
             (state_q == sfcu_pkg::SEQ_GOT_B && !step_in[2]) ||
             (state_q == sfcu_pkg::SEQ_GOT_C && !(step_in[3] && stage1_ok_in)));
      end
   end

   assign unlocked_out = (state_q == sfcu_pkg::SEQ_OPEN);

   always_comb
   begin
      stage_out = `SFCU_STAGE_NONE;
      unique case (state_q)
         sfcu_pkg::SEQ_IDLE: stage_out = `SFCU_STAGE_NONE;
         sfcu_pkg::SEQ_GOT_A: stage_out = `SFCU_STAGE_A;
         sfcu_pkg::SEQ_GOT_B: stage_out = `SFCU_STAGE_B;
         sfcu_pkg::SEQ_GOT_C: stage_out = `SFCU_STAGE_C;
         sfcu_pkg::SEQ_OPEN: stage_out = `SFCU_STAGE_OPEN;
      endcase
   end

endmodule

// [hw/sfcu_fault_clear_regs.sv]
// Self-test fault clear strobes and OTP second-stage unlock registers on Avalon-MM
//
// Behaviour
// - Writing one pulses voltage comparator flag clear
// - Zero writes ignored; clear bits read zero
// - Temperature clear: channels 7..2, UT 1, OT 0
// - Unlock needs first stage plus four confirmations
// - Confirmation registers always read all zeros
// - Any write after unlocking drops the unlock
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "sfcu_defs.svh"

module sfcu_fault_clear_regs
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [`SFCU_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [`SFCU_DATA_W-1:0] avs_writedata_in,
   input wire logic [`SFCU_BE_W-1:0] avs_byteenable_in,
   output logic [`SFCU_DATA_W-1:0] avs_readdata_out,
   output logic [1:0] avs_response_out,
   output logic avs_waitrequest_out,
   input wire logic otp_stage1_unlocked_in,
   output logic overvoltage_compare_fault_clear_out,
   output logic undervoltage_compare_fault_clear_out,
   output logic overtemp_compare_fault_clear_out,
   output logic undertemp_compare_fault_clear_out,
   output logic channel1_selftest_fault_clear_out,
   output logic channel2_selftest_fault_clear_out,
   output logic channel3_selftest_fault_clear_out,
   output logic channel4_selftest_fault_clear_out,
   output logic channel5_selftest_fault_clear_out,
   output logic channel6_selftest_fault_clear_out,
   output logic otp_program_launch_out,
   output logic otp_unlocked_out,
   output logic irq_out
);

   // Register index from a byte address
   function automatic logic [`SFCU_IDX_W-1:0] reg_index(input logic [`SFCU_ADDR_W-1:0] addr);
      reg_index = addr[`SFCU_ADDR_W-1:2];
   endfunction

   // True for every mapped index
   function automatic logic reg_hit(input logic [`SFCU_IDX_W-1:0] idx);
      case (idx)
         `SFCU_IDX_VCLR,
         `SFCU_IDX_TCLR,
         `SFCU_IDX_CONF_A,
         `SFCU_IDX_CONF_B,
         `SFCU_IDX_CONF_C,
         `SFCU_IDX_CONF_D,
         `SFCU_IDX_PROG_CTRL,
         `SFCU_IDX_IRQ_STAT,
         `SFCU_IDX_IRQ_MASK,
         `SFCU_IDX_UNLOCK_STAT,
         `SFCU_IDX_ERR_COUNT:
            reg_hit = 1'b1;
         default:
            reg_hit = 1'b0;
      endcase
   endfunction

   // Write-one-to-clear with set winning over clear
   function automatic logic [`SFCU_IRQ_W-1:0] w1c_update(
      input logic [`SFCU_IRQ_W-1:0] cur,
      input logic [`SFCU_IRQ_W-1:0] clr,
      input logic [`SFCU_IRQ_W-1:0] set);
      w1c_update = (cur & ~clr) | set;
   endfunction

   // A completed write to one register with its low byte lane enabled
   function automatic logic sel_write(
      input logic fire,
      input logic lane,
      input logic [`SFCU_IDX_W-1:0] cur,
      input logic [`SFCU_IDX_W-1:0] target);
      sel_write = fire && lane && (cur == target);
   endfunction

   logic ack_q;
   logic req;
   logic wr_fire;
   logic rd_take;
   logic be0;
   logic [`SFCU_IDX_W-1:0] idx;
   logic [`SFCU_REG_W-1:0] wlo;
   logic wr_vclr;
   logic wr_tclr;
   logic wr_ctrl;
   logic [3:0] step;
   logic launch_req;
   logic wr_stat;
   logic wr_mask;
   logic wr_err;
   logic err_evt;

   logic [`SFCU_DATA_W-1:0] rdata_q;
   logic [`SFCU_DATA_W-1:0] rdata_d;
   logic [1:0] resp_q;
   logic [1:0] resp_d;

   logic ov_clr_q;
   logic uv_clr_q;
   logic ot_clr_q;
   logic ut_clr_q;
   logic [5:0] ch_clr_q;

   logic [`SFCU_IRQ_W-1:0] irq_stat_q;
   logic [`SFCU_IRQ_W-1:0] irq_mask_q;
   logic [`SFCU_IRQ_W-1:0] irq_set;
   logic [`SFCU_IRQ_W-1:0] irq_clr;
   logic [`SFCU_REG_W-1:0] err_count_q;

   logic seq_unlocked;
   logic [`SFCU_STAGE_W-1:0] seq_stage;
   logic seq_launch;
   logic evt_open;
   logic evt_break;
   logic evt_waste;
   logic evt_refuse;

   // Bus handshake: one wait state, answer at the second edge of a request
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign wr_fire = avs_write_in & ack_q;
   assign rd_take = avs_read_in & ~ack_q;

   // ack_q clears itself, so back-to-back requests each wait exactly once
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   assign idx = reg_index(avs_address_in);
   assign be0 = avs_byteenable_in[0];
   assign wlo = avs_writedata_in[`SFCU_REG_W-1:0];

   // Write selects need the low byte lane, the only lane holding fields
   assign wr_vclr = sel_write(wr_fire, be0, idx, `SFCU_IDX_VCLR);
   assign wr_tclr = sel_write(wr_fire, be0, idx, `SFCU_IDX_TCLR);
   assign wr_ctrl = sel_write(wr_fire, be0, idx, `SFCU_IDX_PROG_CTRL);
   assign wr_stat = sel_write(wr_fire, be0, idx, `SFCU_IDX_IRQ_STAT);
   assign wr_mask = sel_write(wr_fire, be0, idx, `SFCU_IDX_IRQ_MASK);
   assign wr_err = sel_write(wr_fire, be0, idx, `SFCU_IDX_ERR_COUNT);

   // Confirmation steps only count with the low byte enabled
   assign step[0] = sel_write(wr_fire, be0, idx, `SFCU_IDX_CONF_A);
   assign step[1] = sel_write(wr_fire, be0, idx, `SFCU_IDX_CONF_B);
   assign step[2] = sel_write(wr_fire, be0, idx, `SFCU_IDX_CONF_C);
   assign step[3] = sel_write(wr_fire, be0, idx, `SFCU_IDX_CONF_D);
   assign launch_req = wr_ctrl && wlo[`SFCU_CTRL_LAUNCH_BIT];

   // Voltage clear strobes: a one pulses, a zero does nothing
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         ov_clr_q <= 1'b0;
      else
         ov_clr_q <= wr_vclr && wlo[`SFCU_VCLR_OV_BIT];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         uv_clr_q <= 1'b0;
      else
         uv_clr_q <= wr_vclr && wlo[`SFCU_VCLR_UV_BIT];
   end

   // Temperature and channel clear strobes
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         ot_clr_q <= 1'b0;
      else
         ot_clr_q <= wr_tclr && wlo[`SFCU_TCLR_OT_BIT];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         ut_clr_q <= 1'b0;
      else
         ut_clr_q <= wr_tclr && wlo[`SFCU_TCLR_UT_BIT];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         ch_clr_q <= 6'h00;
      else
         ch_clr_q <= wr_tclr ? wlo[`SFCU_TCLR_CH6_BIT:`SFCU_TCLR_CH1_BIT] : 6'h00;
   end

   assign overvoltage_compare_fault_clear_out = ov_clr_q;
   assign undervoltage_compare_fault_clear_out = uv_clr_q;
   assign overtemp_compare_fault_clear_out = ot_clr_q;
   assign undertemp_compare_fault_clear_out = ut_clr_q;
   assign channel1_selftest_fault_clear_out = ch_clr_q[0];
   assign channel2_selftest_fault_clear_out = ch_clr_q[1];
   assign channel3_selftest_fault_clear_out = ch_clr_q[2];
   assign channel4_selftest_fault_clear_out = ch_clr_q[3];
   assign channel5_selftest_fault_clear_out = ch_clr_q[4];
   assign channel6_selftest_fault_clear_out = ch_clr_q[5];

   // Every accepted write, mapped or not, reaches the tracker
   // The first-stage flag shares this clock, so it needs no synchroniser
   sfcu_unlock_seq u_seq
   (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .wr_any_in(wr_fire),
      .step_in(step),
      .launch_in(launch_req),
      .stage1_ok_in(otp_stage1_unlocked_in),
      .unlocked_out(seq_unlocked),
      .stage_out(seq_stage),
      .launch_out(seq_launch),
      .evt_open_out(evt_open),
      .evt_break_out(evt_break),
      .evt_waste_out(evt_waste),
      .evt_refuse_out(evt_refuse)
   );

   assign otp_program_launch_out = seq_launch;
   assign otp_unlocked_out = seq_unlocked;

   // Interrupt status: sticky, write one to clear, set wins
   always_comb
   begin
      irq_set = '0;
      irq_set[`SFCU_IRQ_OPEN_BIT] = evt_open;
      irq_set[`SFCU_IRQ_BREAK_BIT] = evt_break;
      irq_set[`SFCU_IRQ_WASTE_BIT] = evt_waste;
      irq_set[`SFCU_IRQ_LAUNCH_BIT] = seq_launch;
      irq_set[`SFCU_IRQ_REFUSE_BIT] = evt_refuse;
   end

   assign irq_clr = wr_stat ?
      wlo[`SFCU_IRQ_W-1:0] : '0;

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         irq_stat_q <= `SFCU_IRQ_STAT_RESET;
      else
         irq_stat_q <= w1c_update(irq_stat_q, irq_clr, irq_set);
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         irq_mask_q <= `SFCU_IRQ_MASK_RESET;
      else if (wr_mask)
         irq_mask_q <= wlo[`SFCU_IRQ_W-1:0];
   end

   // Level output: stays high until every unmasked cause is cleared or masked
   assign irq_out = |(irq_stat_q & irq_mask_q);

   // Broken and wasted attempts both count as failures
   assign err_evt = evt_break || evt_waste;

   // Failed attempts, saturating; a write of any value zeroes it, new errors still count
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         err_count_q <= `SFCU_ERR_RESET;
      else if (err_evt)
      begin
         if (wr_err)
            err_count_q <= `SFCU_ERR_ONE;
         else if (err_count_q != `SFCU_ERR_MAX)
            err_count_q <= err_count_q + `SFCU_ERR_ONE;
      end
      else if (wr_err)
         err_count_q <= `SFCU_ERR_RESET;
   end

   // Read mux; clear and confirmation registers hide what was written
   always_comb
   begin
      rdata_d = `SFCU_RDATA_ZERO;
      resp_d = `SFCU_RESP_OK;
      case (idx)
         `SFCU_IDX_IRQ_STAT:
            rdata_d[`SFCU_IRQ_W-1:0] = irq_stat_q;
         `SFCU_IDX_IRQ_MASK:
            rdata_d[`SFCU_IRQ_W-1:0] = irq_mask_q;
         `SFCU_IDX_UNLOCK_STAT:
         begin
            rdata_d[`SFCU_UST_OPEN_BIT] = seq_unlocked;
            rdata_d[`SFCU_UST_STAGE_MSB:`SFCU_UST_STAGE_LSB] = seq_stage;
            rdata_d[`SFCU_UST_STAGE1_BIT] = otp_stage1_unlocked_in;
         end
         `SFCU_IDX_ERR_COUNT:
            rdata_d[`SFCU_REG_W-1:0] = err_count_q;
         `SFCU_IDX_VCLR,
         `SFCU_IDX_TCLR,
         `SFCU_IDX_CONF_A,
         `SFCU_IDX_CONF_B,
         `SFCU_IDX_CONF_C,
         `SFCU_IDX_CONF_D,
         `SFCU_IDX_PROG_CTRL:
            rdata_d[`SFCU_REG_W-1:0] = `SFCU_CONF_READ;
         // Unmapped index: zero data and a decode error
         default:
            resp_d = `SFCU_RESP_DECODE_ERR;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         rdata_q <= `SFCU_RDATA_ZERO;
      else if (rd_take)
         rdata_q <= rdata_d;
   end

   // Write response is registered too, though Avalon ignores it on writes
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         resp_q <= `SFCU_RESP_OK;
      else if (rd_take)
         resp_q <= resp_d;
      else if (avs_write_in && !ack_q)
         resp_q <= reg_hit(idx) ? `SFCU_RESP_OK : `SFCU_RESP_DECODE_ERR;
   end

   assign avs_readdata_out = rdata_q;
   assign avs_response_out = resp_q;

endmodule

// [dv/sfcu_fault_clear_regs_sva.sv]
// Port-level checker for the fault-clear and unlock register block
`timescale 1ns/10ps
`include "sfcu_defs.svh"

module sfcu_fault_clear_regs_sva
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [`SFCU_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [`SFCU_DATA_W-1:0] avs_writedata_in,
   input wire logic [`SFCU_BE_W-1:0] avs_byteenable_in,
   input wire logic [`SFCU_DATA_W-1:0] avs_readdata_out,
   input wire logic [1:0] avs_response_out,
   input wire logic avs_waitrequest_out,
   input wire logic otp_stage1_unlocked_in,
   input wire logic overvoltage_compare_fault_clear_out,
   input wire logic undervoltage_compare_fault_clear_out,
   input wire logic overtemp_compare_fault_clear_out,
   input wire logic undertemp_compare_fault_clear_out,
   input wire logic channel1_selftest_fault_clear_out,
   input wire logic channel2_selftest_fault_clear_out,
   input wire logic channel3_selftest_fault_clear_out,
   input wire logic channel4_selftest_fault_clear_out,
   input wire logic channel5_selftest_fault_clear_out,
   input wire logic channel6_selftest_fault_clear_out,
   input wire logic otp_program_launch_out,
   input wire logic otp_unlocked_out
);
   logic [9:0] idx;
   logic wfin, wstb, rfin, go;
   logic [7:0] tclr;
   assign idx = avs_address_in[11:2];
   assign wfin = avs_write_in && !avs_waitrequest_out;
   assign wstb = wfin && avs_byteenable_in[0];
   assign rfin = avs_read_in && !avs_waitrequest_out;
   assign go = wstb && idx == `SFCU_IDX_PROG_CTRL && avs_writedata_in[0];
   assign tclr = {channel6_selftest_fault_clear_out, channel5_selftest_fault_clear_out,
      channel4_selftest_fault_clear_out, channel3_selftest_fault_clear_out,
      channel2_selftest_fault_clear_out, channel1_selftest_fault_clear_out,
      undertemp_compare_fault_clear_out, overtemp_compare_fault_clear_out};

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   a_volt_strobe:
      assert property ({overvoltage_compare_fault_clear_out, undervoltage_compare_fault_clear_out}
         == ($past(wstb && idx == `SFCU_IDX_VCLR) ? $past(avs_writedata_in[1:0]) : 2'h0))
      else $error("voltage strobe mismatch");
   a_temp_strobe:
      assert property (tclr == ($past(wstb && idx == `SFCU_IDX_TCLR) ?
         $past(avs_writedata_in[7:0]) : 8'h00))
      else $error("temperature strobe mismatch");
   a_one_wait:
      assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait state not one cycle");
   a_zero_readback:
      assert property (rfin && idx inside {[`SFCU_IDX_CONF_A:`SFCU_IDX_CONF_D], `SFCU_IDX_VCLR,
         `SFCU_IDX_TCLR} |-> avs_readdata_out == 32'h0000_0000)
      else $error("clear or confirm register read nonzero");
   a_unmapped_resp:
      assert property (rfin && idx == 10'h001 |-> avs_response_out == `SFCU_RESP_DECODE_ERR)
      else $error("unmapped read not refused");
   a_unlock_cause:
      assert property ($rose(otp_unlocked_out) |->
         $past(wfin && idx == `SFCU_IDX_CONF_D && otp_stage1_unlocked_in))
      else $error("unlock without final confirmation");
   a_write_relocks:
      assert property (otp_unlocked_out && wfin |=> !otp_unlocked_out)
      else $error("unlock survived a write");
   a_launch_cause:
      assert property (otp_program_launch_out |-> $past(otp_unlocked_out && go))
      else $error("launch without unlock");
   a_launch_given:
      assert property (otp_unlocked_out && go |=> otp_program_launch_out ##1 !otp_program_launch_out)
      else $error("launch pulse missing");
endmodule

bind sfcu_fault_clear_regs sfcu_fault_clear_regs_sva u_sva (.clk_sys_in, .reset_in,
   .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_readdata_out, .avs_response_out, .avs_waitrequest_out, .otp_stage1_unlocked_in,
   .overvoltage_compare_fault_clear_out, .undervoltage_compare_fault_clear_out,
   .overtemp_compare_fault_clear_out, .undertemp_compare_fault_clear_out,
   .channel1_selftest_fault_clear_out, .channel2_selftest_fault_clear_out,
   .channel3_selftest_fault_clear_out, .channel4_selftest_fault_clear_out,
   .channel5_selftest_fault_clear_out, .channel6_selftest_fault_clear_out,
   .otp_program_launch_out, .otp_unlocked_out);

// [dv/sfcu_fault_clear_regs_test.sv]
// Register-level testbench for the fault-clear and unlock block
`timescale 1ns/10ps
`include "sfcu_defs.svh"

module sfcu_fault_clear_regs_test;
   logic clk_sys_in, reset_in, rd, wr, stage1, wreq, irq, unl, ov, uv, ot, ut, launch;
   logic [11:0] addr;
   logic [31:0] wd, rdata, rv;
   logic [3:0] be;
   logic [1:0] resp, rs;
   logic [6:1] ch;
   logic [10:0] pv;
   int fail_count, n_checks, k;
   logic [9:0] regs [11] = '{`SFCU_IDX_VCLR, `SFCU_IDX_TCLR, `SFCU_IDX_CONF_A, `SFCU_IDX_CONF_B,
      `SFCU_IDX_CONF_C, `SFCU_IDX_CONF_D, `SFCU_IDX_PROG_CTRL, `SFCU_IDX_IRQ_STAT,
      `SFCU_IDX_IRQ_MASK, `SFCU_IDX_UNLOCK_STAT, `SFCU_IDX_ERR_COUNT};

   sfcu_fault_clear_regs u_dut
   (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_response_out(resp), .avs_waitrequest_out(wreq),
      .otp_stage1_unlocked_in(stage1), .overvoltage_compare_fault_clear_out(ov),
      .undervoltage_compare_fault_clear_out(uv), .overtemp_compare_fault_clear_out(ot),
      .undertemp_compare_fault_clear_out(ut), .channel1_selftest_fault_clear_out(ch[1]),
      .channel2_selftest_fault_clear_out(ch[2]), .channel3_selftest_fault_clear_out(ch[3]),
      .channel4_selftest_fault_clear_out(ch[4]), .channel5_selftest_fault_clear_out(ch[5]),
      .channel6_selftest_fault_clear_out(ch[6]), .otp_program_launch_out(launch),
      .otp_unlocked_out(unl), .irq_out(irq)
   );

   initial
   begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One Avalon transfer; the slave may stall, so the wait is bounded, not assumed
   task automatic bus(input logic w, input logic [9:0] ix, input logic [7:0] d,
      input logic [3:0] b);
      logic done;
      done = 1'b0;
      @(posedge clk_sys_in);
      wr <= w;
      rd <= !w;
      addr <= {ix, 2'b00};
      wd <= {24'h000000, d};
      be <= b;
      for (int n = 0; n < 20 && !done; n++)
      begin
         @(posedge clk_sys_in);
         done = (wreq === 1'b0);
      end
      rv = rdata;
      rs = resp;
      wr <= 1'b0;
      rd <= 1'b0;
      if (!done)
      begin
         fail_count++;
         $display("ERROR waitrequest expected 0 seen 1");
         conclude();
      end
      @(negedge clk_sys_in);
      pv = {ov, uv, ch, ut, ot, launch};
   endtask

   task automatic wr8(input logic [9:0] ix, input logic [7:0] d);
      bus(1'b1, ix, d, 4'h1);
   endtask

   task automatic rd_chk(input logic [9:0] ix, input logic [7:0] exp);
      bus(1'b0, ix, 8'h00, 4'hf);
      check($sformatf("reg %h", ix), {24'h000000, exp}, rv);
   endtask

   task automatic unlock4;
      for (int j = 0; j < 4; j++)
         wr8(`SFCU_IDX_CONF_A + 10'(j), 8'ha5);
   endtask

   task automatic set_stage1(input logic v);
      @(posedge clk_sys_in);
      stage1 <= v;
   endtask

   initial
   begin
      fail_count = 0;
      n_checks = 0;
      reset_in = 1'b1;
      {rd, wr, stage1} = 3'h0;
      addr = 12'h000;
      wd = 32'h0000_0000;
      be = 4'h0;
      repeat (12) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      for (k = 0; k < 11; k++)
         rd_chk(regs[k], 8'h00);
      bus(1'b0, 10'h001, 8'h00, 4'hf);
      check("unmapped response", 32'h3, {30'h0, rs});
      for (k = 0; k < 2; k++)
      begin
         wr8(`SFCU_IDX_VCLR, 8'h01 << k);
         check("voltage strobes", 32'h200 << k, {21'h0, pv});
      end
      for (k = 0; k < 8; k++)
      begin
         wr8(`SFCU_IDX_TCLR, 8'h01 << k);
         check("temperature strobes", 32'h2 << k, {21'h0, pv});
      end
      wr8(`SFCU_IDX_VCLR, 8'hfc);
      check("reserved strobes", 32'h0, {21'h0, pv});
      wr8(`SFCU_IDX_TCLR, 8'h00);
      check("zero write strobes", 32'h0, {21'h0, pv});
      bus(1'b1, `SFCU_IDX_TCLR, 8'hff, 4'h0);
      check("disabled lane strobes", 32'h0, {21'h0, pv});
      wr8(`SFCU_IDX_TCLR, 8'hff);
      check("all temperature strobes", 32'h1fe, {21'h0, pv});
      rd_chk(`SFCU_IDX_TCLR, 8'h00);
      set_stage1(1'b1);
      unlock4();
      check("unlocked", 32'h1, {31'h0, unl});
      rd_chk(`SFCU_IDX_CONF_C, 8'h00);
      rd_chk(`SFCU_IDX_UNLOCK_STAT, 8'h19);
      wr8(`SFCU_IDX_PROG_CTRL, 8'h01);
      check("launch", 32'h1, {21'h0, pv});
      check("relocked", 32'h0, {31'h0, unl});
      unlock4();
      wr8(`SFCU_IDX_VCLR, 8'h00);
      check("wasted unlock", 32'h0, {31'h0, unl});
      wr8(`SFCU_IDX_PROG_CTRL, 8'h01);
      check("locked launch", 32'h0, {21'h0, pv});
      wr8(`SFCU_IDX_CONF_A, 8'h10);
      wr8(`SFCU_IDX_CONF_B, 8'h11);
      wr8(`SFCU_IDX_CONF_D, 8'h33);
      wr8(`SFCU_IDX_CONF_C, 8'h22);
      check("broken order", 32'h0, {31'h0, unl});
      rd_chk(`SFCU_IDX_UNLOCK_STAT, 8'h10);
      wr8(`SFCU_IDX_CONF_A, 8'h44);
      unlock4();
      check("restart", 32'h1, {31'h0, unl});
      wr8(`SFCU_IDX_IRQ_MASK, 8'h00);
      set_stage1(1'b0);
      unlock4();
      check("first stage missing", 32'h0, {31'h0, unl});
      rd_chk(`SFCU_IDX_ERR_COUNT, 8'h04);
      rd_chk(`SFCU_IDX_IRQ_STAT, 8'h1f);
      wr8(`SFCU_IDX_IRQ_STAT, 8'h1f);
      rd_chk(`SFCU_IDX_IRQ_STAT, 8'h00);
      wr8(`SFCU_IDX_IRQ_MASK, 8'h01);
      set_stage1(1'b1);
      unlock4();
      wr8(`SFCU_IDX_PROG_CTRL, 8'h01);
      rd_chk(`SFCU_IDX_IRQ_STAT, 8'h09);
      check("irq raised", 32'h1, {31'h0, irq});
      wr8(`SFCU_IDX_IRQ_STAT, 8'h01);
      rd_chk(`SFCU_IDX_IRQ_STAT, 8'h08);
      check("irq masked", 32'h0, {31'h0, irq});
      wr8(`SFCU_IDX_IRQ_MASK, 8'h08);
      check("irq unmasked", 32'h1, {31'h0, irq});
      wr8(`SFCU_IDX_IRQ_STAT, 8'h08);
      check("irq cleared", 32'h0, {31'h0, irq});
      conclude();
   end
endmodule
